// ===== design/rx_drop_pkg.sv
// package: offsets, field positions, reset values and timing for the register slice
package rx_drop_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DROP_COUNT = 8'hA0;
  localparam logic [7:0] OFS_MAC_CMD    = 8'hA4;
  localparam logic [7:0] OFS_MAC_DATA   = 8'hA8;
  localparam logic [7:0] OFS_PAUSE_CFG  = 8'hAC;
  // command register fields
  localparam int CMD_BUSY_BIT = 31;
  localparam int CMD_DIR_BIT  = 30;
  localparam int CMD_ADDR_MSB = 7;
  // pause config fields
  localparam int CFG_HI_LSB  = 16;
  localparam int CFG_LO_LSB  = 8;
  localparam int CFG_DUR_LSB = 4;
  localparam int CFG_MULT    = 3;
  localparam int CFG_BCAST   = 2;
  localparam int CFG_OWN     = 1;
  localparam int CFG_ANY     = 0;
  // reset values and the drop tally midpoint
  localparam logic [31:0] DROP_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [7:0]  ADDR_RESET = 8'h00;
  localparam logic [23:0] CFG_RESET  = 24'h00_0000;
  localparam logic [31:0] DROP_MID   = 32'h8000_0000;
  // jam durations at 100 Mb/s, in microseconds, per duration code
  localparam int CLK_MHZ = 125;
  localparam int JAM_US [16] = '{5, 10, 15, 25, 50, 100, 150, 200,
                                 250, 300, 350, 400, 450, 500, 550, 600};
  localparam int JAM_W = 17;
endpackage : rx_drop_pkg

// ===== design/mac_access_if.sv
// interface: request and completion signals between bank and access sequencer
`timescale 1ns/10ps
interface mac_access_if;
  logic        start;
  logic        dir_read;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        busy;
  logic        done;
  logic [31:0] rdata;
  modport bank (output start, dir_read, addr, wdata, input busy, done, rdata);
  modport seq  (input start, dir_read, addr, wdata, output busy, done, rdata);
endinterface : mac_access_if

// ===== design/mac_access_seq.sv
// module: sequencer that performs one internal mac register access per request
`timescale 1ns/10ps
module mac_access_seq (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // bank side
  mac_access_if.seq        acc,
  // mac register port
  output logic             mreg_req_o,
  output logic             mreg_wr_o,
  output logic [7:0]       mreg_addr_o,
  output logic [31:0]      mreg_wdata_o,
  input  wire logic        mreg_ack_i,
  input  wire logic [31:0] mreg_rdata_i
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DONE} seq_state_t;
  seq_state_t state_r;

  // request held stable to the mac until it acknowledges
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r      <= S_IDLE;
      mreg_req_o   <= 1'b0;
      mreg_wr_o    <= 1'b0;
      mreg_addr_o  <= 8'h00;
      mreg_wdata_o <= 32'h0000_0000;
      acc.rdata    <= 32'h0000_0000;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (acc.start) begin // R21
            mreg_req_o   <= 1'b1;
            mreg_wr_o    <= ~acc.dir_read;
            mreg_addr_o  <= acc.addr;
            mreg_wdata_o <= acc.wdata;
            state_r      <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (mreg_ack_i) begin
            mreg_req_o <= 1'b0;
            if (!mreg_wr_o) begin
              acc.rdata <= mreg_rdata_i; // R5
            end
            state_r <= S_DONE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  assign acc.busy = (state_r != S_IDLE);
  assign acc.done = (state_r == S_DONE);
endmodule : mac_access_seq

// ===== design/rx_drop_csr_bridge_pause_cfg.sv
// module: dropped frame counter, mac register bridge and automatic pause control
// Operation
// R1 - each discarded receive frame increments the dropped frame tally by one
// R2 - reading the tally returns it and clears it; resets to zero
// R3 - a midpoint event pulses when the tally's top bit becomes set
// R4 - writing one to command bit 31 starts the selected mac register access
// R5 - busy stays set until access completes; read data lands in data register
// R6 - host leaves command and data registers alone while busy is set
// R7 - command bit 30 picks direction, one read and zero write; resets zero
// R8 - command bits 7 to 0 hold the address; bits 29 to 8 read zero
// R9 - the 32-bit data register carries write or read value; resets zero
// R10 - no pause frames or back pressure while the transmitter is disabled
// R11 - high threshold in 64-byte units triggers pause or jam per trigger bits
// R12 - full duplex: reaching high threshold sends exactly one timed pause frame
// R13 - half duplex: each matching incoming frame is jammed for the set duration
// R14 - falling below low threshold sends a zero-time pause frame
// R15 - zero-time pause only after a timed pause and while pausing is enabled
// R16 - software keeps the low threshold below the high threshold
// R17 - bits 7 to 4 choose the jam duration; unused in full duplex
// R18 - bits 3, 2, 1 enable jam on multicast, broadcast, own-address frames
// R19 - bit 0 triggers on any frame, enables full-duplex pause, overrides 3..1
// R20 - tally wraps to zero; a drop during a clearing read counts afterwards
// R21 - request, address, direction and data pass safely to the mac access side
`timescale 1ns/10ps
module rx_drop_csr_bridge_pause_cfg (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // host register port
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  output logic             reg_sel_o,
  // receive events
  input  wire logic        rx_drop_i,
  output logic             drop_mid_event_o,
  // mac register port
  output logic             mreg_req_o,
  output logic             mreg_wr_o,
  output logic [7:0]       mreg_addr_o,
  output logic [31:0]      mreg_wdata_o,
  input  wire logic        mreg_ack_i,
  input  wire logic [31:0] mreg_rdata_i,
  // flow control inputs
  input  wire logic        tx_enabled_i,
  input  wire logic        full_duplex_i,
  input  wire logic [7:0]  rx_fifo_level_i,
  input  wire logic        rx_frame_start_i,
  input  wire logic        rx_frame_mcast_i,
  input  wire logic        rx_frame_bcast_i,
  input  wire logic        rx_frame_own_i,
  // flow control outputs
  output logic             pause_send_o,
  output logic             pause_zero_o,
  output logic             jam_o
);
  logic [31:0] drop_count_r;
  logic        dir_read_r;
  logic [7:0]  addr_r;
  logic [31:0] data_r;
  logic [23:0] cfg_r;
  logic        start_r;
  logic        paused_r;
  localparam int JAM_W_L = rx_drop_pkg::JAM_W;
  logic [JAM_W_L-1:0] jam_cnt_r;

  mac_access_if acc ();

  // access sequencer
  mac_access_seq u_seq (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .acc          (acc),
    .mreg_req_o   (mreg_req_o),
    .mreg_wr_o    (mreg_wr_o),
    .mreg_addr_o  (mreg_addr_o),
    .mreg_wdata_o (mreg_wdata_o),
    .mreg_ack_i   (mreg_ack_i),
    .mreg_rdata_i (mreg_rdata_i)
  );

  // decode strobes
  logic rd_drop, wr_cmd, wr_data, wr_cfg;
  assign rd_drop = reg_rd_i && (reg_addr_i == rx_drop_pkg::OFS_DROP_COUNT);
  assign wr_cmd  = reg_wr_i && (reg_addr_i == rx_drop_pkg::OFS_MAC_CMD);
  assign wr_data = reg_wr_i && (reg_addr_i == rx_drop_pkg::OFS_MAC_DATA);
  assign wr_cfg  = reg_wr_i && (reg_addr_i == rx_drop_pkg::OFS_PAUSE_CFG);

  // dropped frame tally, clear on read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drop_count_r <= rx_drop_pkg::DROP_RESET; // R2
    end else if (rd_drop) begin
      drop_count_r <= {31'h0000_0000, rx_drop_i}; // R2 R20
    end else if (rx_drop_i) begin
      drop_count_r <= drop_count_r + 32'h0000_0001; // R1 R20
    end
  end

  // midpoint event pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drop_mid_event_o <= 1'b0;
    end else begin
      drop_mid_event_o <= rx_drop_i && !rd_drop
                          && (drop_count_r == rx_drop_pkg::DROP_MID - 32'h0000_0001); // R3
    end
  end

  // command register and start pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dir_read_r <= 1'b0; // R7
      addr_r     <= rx_drop_pkg::ADDR_RESET; // R8
      start_r    <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (wr_cmd && !acc.busy && !start_r) begin
        dir_read_r <= reg_wdata_i[rx_drop_pkg::CMD_DIR_BIT]; // R7
        addr_r     <= reg_wdata_i[rx_drop_pkg::CMD_ADDR_MSB:0]; // R8
        start_r    <= reg_wdata_i[rx_drop_pkg::CMD_BUSY_BIT]; // R4
      end
    end
  end

  // data register: host writes, or read result on completion
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_r <= rx_drop_pkg::DATA_RESET; // R9
    end else if (acc.done && dir_read_r) begin
      data_r <= acc.rdata; // R5
    end else if (wr_data && !acc.busy && !start_r) begin
      data_r <= reg_wdata_i; // R9 R6
    end
  end

  assign acc.start    = start_r; // R21
  assign acc.dir_read = dir_read_r;
  assign acc.addr     = addr_r;
  assign acc.wdata    = data_r;

  // pause configuration register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_r <= rx_drop_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= reg_wdata_i[23:0];
    end
  end

  // read mux
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0000_0000;
      reg_sel_o   <= 1'b0;
    end else begin
      reg_sel_o <= 1'b0;
      if (reg_rd_i) begin
        reg_sel_o <= 1'b1;
        if (reg_addr_i == rx_drop_pkg::OFS_DROP_COUNT) begin
          reg_rdata_o <= drop_count_r; // R2
        end else if (reg_addr_i == rx_drop_pkg::OFS_MAC_CMD) begin
          reg_rdata_o <= {acc.busy | start_r, dir_read_r, 22'h00_0000, addr_r}; // R5 R8
        end else if (reg_addr_i == rx_drop_pkg::OFS_MAC_DATA) begin
          reg_rdata_o <= data_r;
        end else if (reg_addr_i == rx_drop_pkg::OFS_PAUSE_CFG) begin
          reg_rdata_o <= {8'h00, cfg_r};
        end else begin
          reg_rdata_o <= 32'h0000_0000;
          reg_sel_o   <= 1'b0;
        end
      end
    end
  end

  // flow control decode
  logic [7:0] hi_lvl, lo_lvl;
  logic       any_en, match, reached;
  assign hi_lvl  = cfg_r[rx_drop_pkg::CFG_HI_LSB +: 8];
  assign lo_lvl  = cfg_r[rx_drop_pkg::CFG_LO_LSB +: 8];
  assign any_en  = cfg_r[rx_drop_pkg::CFG_ANY];
  assign reached = rx_fifo_level_i >= hi_lvl; // R11
  assign match   = any_en // R19
                 || (cfg_r[rx_drop_pkg::CFG_MULT] && rx_frame_mcast_i)
                 || (cfg_r[rx_drop_pkg::CFG_BCAST] && rx_frame_bcast_i)
                 || (cfg_r[rx_drop_pkg::CFG_OWN] && rx_frame_own_i); // R18

  // full-duplex pause frames
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      paused_r     <= 1'b0;
      pause_send_o <= 1'b0;
      pause_zero_o <= 1'b0;
    end else begin
      pause_send_o <= 1'b0;
      pause_zero_o <= 1'b0;
      if (!any_en || !full_duplex_i) begin
        paused_r <= 1'b0; // R15
      end else if (tx_enabled_i) begin // R10
        if (!paused_r && reached) begin
          pause_send_o <= 1'b1; // R12
          paused_r     <= 1'b1;
        end else if (paused_r && rx_fifo_level_i < lo_lvl) begin
          pause_zero_o <= 1'b1; // R14 R15
          paused_r     <= 1'b0;
        end
      end
    end
  end

  // half-duplex jam timer
  function automatic logic [JAM_W_L-1:0] jam_cycles(input logic [3:0] code);
    jam_cycles = JAM_W_L'(rx_drop_pkg::JAM_US[code] * rx_drop_pkg::CLK_MHZ);
  endfunction : jam_cycles

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      jam_cnt_r <= '0;
      jam_o     <= 1'b0;
    end else if (!tx_enabled_i || full_duplex_i) begin
      jam_cnt_r <= '0; // R10
      jam_o     <= 1'b0;
    end else if (rx_frame_start_i && reached && match) begin
      jam_cnt_r <= jam_cycles(cfg_r[rx_drop_pkg::CFG_DUR_LSB +: 4]); // R13 R17
      jam_o     <= 1'b1;
    end else if (jam_cnt_r > JAM_W_L'(1)) begin
      jam_cnt_r <= jam_cnt_r - JAM_W_L'(1);
    end else begin
      jam_cnt_r <= '0;
      jam_o     <= 1'b0;
    end
  end
endmodule : rx_drop_csr_bridge_pause_cfg

// ===== bench/mac_reg_model.sv
// model: mac register space answering the access sequencer
`timescale 1ns/10ps
module mac_reg_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // access port from the block
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  lat_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem_r [256];
  logic [3:0]  wait_r;

  // one-cycle ack after lat_i idle cycles; read data churns when not answering
  always_ff @(posedge clk_i) begin
    ack_o   <= 1'h0;
    rdata_o <= ~rdata_o;
    if (srst_i) begin
      wait_r  <= 4'h0;
      rdata_o <= 32'h0;
    end else if (req_i && !ack_o) begin
      if (wait_r == lat_i) begin
        ack_o   <= 1'h1;
        wait_r  <= 4'h0;
        rdata_o <= mem_r[addr_i];
        if (wr_i)
          mem_r[addr_i] <= wdata_i;
      end else
        wait_r <= wait_r + 4'h1;
    end
  end
endmodule : mac_reg_model

// ===== bench/rx_drop_sva.sv
// checker: port-level assertions for the register slice
`timescale 1ns/10ps
module rx_drop_sva (
  // clock, reset, host port
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_sel_o,
  // drop events
  input wire logic        rx_drop_i,
  input wire logic        drop_mid_event_o,
  // mac port and flow control
  input wire logic        mreg_req_o,
  input wire logic        mreg_wr_o,
  input wire logic [7:0]  mreg_addr_o,
  input wire logic        mreg_ack_i,
  input wire logic        tx_enabled_i,
  input wire logic        full_duplex_i,
  input wire logic        rx_frame_start_i,
  input wire logic        pause_send_o,
  input wire logic        pause_zero_o,
  input wire logic        jam_o
);
  logic hit;

  // mapped offset decode
  assign hit = reg_addr_i inside {8'hA0, 8'hA4, 8'hA8, 8'hAC};
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  start_req_a: assert property (
    reg_wr_i && reg_addr_i == 8'hA4 && reg_wdata_i[31] && !mreg_req_o |-> ##2 mreg_req_o
    && mreg_wr_o != $past(reg_wdata_i[30], 2) && mreg_addr_o == $past(reg_wdata_i[7:0], 2))
    else $error("access launch wrong");
  req_hold_a: assert property (
    mreg_req_o && !mreg_ack_i |=> mreg_req_o && $stable(mreg_addr_o) && $stable(mreg_wr_o))
    else $error("request dropped early");
  rd_sel_a: assert property (reg_rd_i && hit |=> reg_sel_o)
    else $error("mapped read not selected");
  rd_unmap_a: assert property (
    reg_rd_i && !hit |=> !reg_sel_o && reg_rdata_o == 32'h0)
    else $error("unmapped read wrong");
  rd_rsvd_a: assert property (
    reg_rd_i && reg_addr_i == 8'hA4 |=> reg_rdata_o[29:8] == 22'h0)
    else $error("reserved bits set");
  tx_off_a: assert property (
    (!tx_enabled_i) [*2] |-> !pause_send_o && !pause_zero_o)
    else $error("pause while tx off");
  pause_one_a: assert property (
    pause_send_o |-> $past(full_duplex_i) ##1 !pause_send_o)
    else $error("pause pulse wrong");
  zero_gap_a: assert property (pause_zero_o |-> !pause_send_o ##1 !pause_zero_o)
    else $error("zero pause pulse wrong");
  jam_rise_a: assert property (
    $rose(jam_o) |-> $past(rx_frame_start_i) && !$past(full_duplex_i) && $past(tx_enabled_i))
    else $error("jam without cause");
  mid_cause_a: assert property (
    drop_mid_event_o |-> $past(rx_drop_i) ##1 !drop_mid_event_o)
    else $error("midpoint event without drop");
endmodule : rx_drop_sva

bind rx_drop_csr_bridge_pause_cfg rx_drop_sva rx_drop_sva_i (.*);

// ===== bench/rx_drop_csr_bridge_pause_cfg_tb.sv
// testbench: register slice against a mac register model
`timescale 1ns/10ps
module rx_drop_csr_bridge_pause_cfg_tb;
  logic        clk_i = 0, srst_i = 1, reg_rd_i = 0, reg_wr_i = 0, rx_drop_i = 0, rd_d = 0;
  logic        tx_enabled_i = 0, full_duplex_i = 0, rx_frame_start_i = 0, rx_frame_mcast_i = 0;
  logic        rx_frame_bcast_i = 0, rx_frame_own_i = 0, mreg_ack_i, reg_sel_o, jam_o;
  logic        drop_mid_event_o, mreg_req_o, mreg_wr_o, pause_send_o, pause_zero_o;
  logic [7:0]  reg_addr_i = 0, rx_fifo_level_i = 0, mreg_addr_o;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, mreg_wdata_o, mreg_rdata_i, v;
  logic [32:0] x, exp_q[$];
  logic [3:0]  lat = 0;
  int          num_errors = 0, checked = 0, seed = 19, n, n_send = 0, n_zero = 0, n_jam = 0;

  rx_drop_csr_bridge_pause_cfg rx_drop_csr_bridge_pause_cfg_i (.*);
  mac_reg_model mac_reg_model_i (.clk_i(clk_i), .srst_i(srst_i), .req_i(mreg_req_o),
    .wr_i(mreg_wr_o), .addr_i(mreg_addr_o), .wdata_i(mreg_wdata_o), .lat_i(lat),
    .ack_o(mreg_ack_i), .rdata_o(mreg_rdata_i));

  // clock
  always #4 clk_i = ~clk_i;

  // compare each read answer with the oldest note when its check flag is set; count pause pulses and jam cycles
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i;
    n_send += pause_send_o;
    n_zero += pause_zero_o;
    n_jam  += jam_o;
    if (rd_d) begin
      x = exp_q.pop_front();
      if (x[32])
        chk(reg_rdata_o, x[31:0]);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'h1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e);
    @(posedge clk_i);
    reg_rd_i   <= 1'h1;
    reg_addr_i <= a;
    exp_q.push_back({c, e});
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
  endtask : rd

  task automatic wait_idle;
    for (int i = 0; i < 60; i++) begin
      rd(8'hA4, 1'h0, 32'h0);
      @(posedge clk_i);
      if (reg_rdata_o[31] === 1'h0)
        return;
    end
    num_errors++;
    results();
  endtask : wait_idle

  task automatic lvl(input logic [7:0] l);
    rx_fifo_level_i <= l;
    repeat (20) @(posedge clk_i);
  endtask : lvl

  task automatic frame(input logic [2:0] f);
    @(posedge clk_i);
    rx_frame_start_i <= 1'h1;
    {rx_frame_mcast_i, rx_frame_bcast_i, rx_frame_own_i} <= f;
    @(posedge clk_i);
    rx_frame_start_i <= 1'h0;
  endtask : frame

  task automatic results;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'h0;
    for (int a = 0; a < 5; a++) rd(8'hA0 + 8'(a * 4), 1'h1, 32'h0);
    n = 5 + ($random(seed) & 7);
    repeat (n) begin
      @(posedge clk_i);
      rx_drop_i <= 1'h1;
      @(posedge clk_i);
      rx_drop_i <= 1'h0;
    end
    rd(8'hA0, 1'h1, n);
    rx_drop_i <= 1'h1;
    rd(8'hA0, 1'h1, 32'h1);
    rx_drop_i <= 1'h0;
    rd(8'hA0, 1'h1, 32'h1);
    v = $random(seed);
    wr(8'hAC, v);
    rd(8'hAC, 1'h1, {8'h00, v[23:0]});
    for (int k = 0; k < 2; k++) begin
      lat <= k ? 4'h9 : 4'h0;
      v = $random(seed);
      wr(8'hA8, v);
      wr(8'hA4, {24'h800000, 8'(k + 3)});
      wait_idle();
      wr(8'hA8, 32'h0);
      wr(8'hA4, {24'hC00000, 8'(k + 3)});
      wait_idle();
      rd(8'hA8, 1'h1, v);
      rd(8'hA4, 1'h1, {24'h400000, 8'(k + 3)});
    end
    wr(8'hAC, 32'h0010_0801);
    full_duplex_i <= 1'h1;
    tx_enabled_i  <= 1'h1;
    lvl(8'h00);
    chk(n_zero, 0);
    lvl(8'h10);
    chk(n_send, 1);
    lvl(8'h08);
    chk(n_zero, 0);
    lvl(8'h07);
    chk(n_zero, 1);
    tx_enabled_i <= 1'h0;
    lvl(8'h20);
    lvl(8'h00);
    chk(n_send + n_zero, 2);
    wr(8'hAC, 32'h0010_0008);
    full_duplex_i <= 1'h0;
    tx_enabled_i  <= 1'h1;
    lvl(8'h20);
    frame(3'h2);
    lvl(8'h20);
    chk(n_jam, 0);
    frame(3'h4);
    repeat (700) @(posedge clk_i);
    chk(n_jam, rx_drop_pkg::JAM_US[0] * rx_drop_pkg::CLK_MHZ);
    results();
  end
endmodule : rx_drop_csr_bridge_pause_cfg_tb
